/* File: rtl/sps_map.svh */
// Address map, field positions, reset values and page codes of the page stack.
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH
`define SPS_IDX_CTRL     8'h84
`define SPS_IDX_MIDDLE   8'h85
`define SPS_IDX_BOTTOM   8'h86
`define SPS_IDX_PAGE     8'hA7
`define SPS_AEN_BIT      0
`define SPS_RST_AEN      1'b1
`define SPS_RST_PAGE     8'h00
`define SPS_PAGE_LO      8'h00
`define SPS_PAGE_CAN     8'h0C
`define SPS_PAGE_CF      8'h0F
`define SPS_PORT0        8'h80
`define SPS_PORT1        8'h90
`define SPS_PORT2        8'hA0
`define SPS_PORT3        8'hB0
`endif

/* File: rtl/sps_page_stack.sv */
// Paged register decoder with a three-level page stack and an AHB-Lite slave.
//
// Overview of operation
// - Direct accesses to 0x80..0xFF select register space, not data memory.
// - Addresses ending 0x0 or 0x8 allow bit access; others byte access only.
// - An 8-bit page selector picks which register an address decodes to.
// - Only pages 0x00, 0x0C and 0x0F carry registers.
// - The stack holds current page, middle and bottom bytes.
// - Interrupt entry shifts middle to bottom and current page to middle.
// - Entry then loads page 0x00, or 0x0C for the CAN controller.
// - Interrupt return moves middle back into the current page.
// - The same pop moves bottom to middle; empty bottom reads 0x00.
// - All three stack bytes are readable and writable by software.
// - Software writes change one entry only and never push or pop.
// - Automatic paging is enabled at reset until software clears it.
// - With paging disabled, entry and return leave page and stack alone.
// - Port registers decode on every page regardless of the selector.
// - Page selector reads the page in use; writes set it at once.
// - Control bit 0 is the enable, reset 1; bits 7..1 read zero.
//
// Added by the designer: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "sps_map.svh"

module sps_page_stack
  import sps_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire sps_access_t core_acc,
  input  wire sps_irq_t    irq_evt,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output sps_decode_t      decode,
  output logic [7:0]       current_page_select,
  output logic             auto_page_enable
);

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic logic is_all_pages(input logic [7:0] a);
    is_all_pages = (a == `SPS_PORT0) || (a == `SPS_PORT1) ||
                   (a == `SPS_PORT2) || (a == `SPS_PORT3) ||
                   (a == `SPS_IDX_PAGE) || (a == `SPS_IDX_MIDDLE) ||
                   (a == `SPS_IDX_BOTTOM);
  endfunction : is_all_pages

  function automatic logic is_bit_addr(input logic [7:0] a);
    is_bit_addr = (a[2:0] == 3'h0);
  endfunction : is_bit_addr

  function automatic logic is_known_page(input logic [7:0] p);
    is_known_page = (p == `SPS_PAGE_LO) || (p == `SPS_PAGE_CAN) ||
                    (p == `SPS_PAGE_CF);
  endfunction : is_known_page

  // ----------------------------------------------------------------
  // Stack state
  // ----------------------------------------------------------------
  logic [7:0] page_stack_middle;
  logic [7:0] page_stack_bottom;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic       dp_valid;
  logic       dp_write;
  logic [7:0] dp_idx;

  wire        ap_take   = hsel & htrans[1] & hready;
  wire        ap_mapped = (haddr[31:10] == 22'h000000) &&
                          (haddr[1:0] == 2'h0);
  wire [7:0]  ap_idx    = haddr[9:2];
  wire [7:0]  wbyte     = hwdata[7:0];
  wire        dp_wr     = dp_valid & dp_write;
  wire        wr_ctrl   = dp_wr & (dp_idx == `SPS_IDX_CTRL);
  wire        wr_page   = dp_wr & (dp_idx == `SPS_IDX_PAGE);
  wire        wr_mid    = dp_wr & (dp_idx == `SPS_IDX_MIDDLE);
  wire        wr_bot    = dp_wr & (dp_idx == `SPS_IDX_BOTTOM);

  // ----------------------------------------------------------------
  // Push and pop
  // ----------------------------------------------------------------
  // Entry wins if both events coincide; the core never retires a
  // return in the cycle it takes a new vector.
  wire       push     = irq_evt.enter & auto_page_enable;
  wire       pop      = irq_evt.ret & ~irq_evt.enter & auto_page_enable;
  wire [7:0] irq_page = irq_evt.is_can ? `SPS_PAGE_CAN : `SPS_PAGE_LO;

  // Hardware stack motion overrides a software write in the same cycle.
  wire [7:0] next_page = push    ? irq_page          :
                         pop     ? page_stack_middle :
                         wr_page ? wbyte             :
                         current_page_select;
  wire [7:0] next_mid  = push    ? current_page_select :
                         pop     ? page_stack_bottom   :
                         wr_mid  ? wbyte               :
                         page_stack_middle;
  wire [7:0] next_bot  = push    ? page_stack_middle :
                         pop     ? `SPS_RST_PAGE     :
                         wr_bot  ? wbyte             :
                         page_stack_bottom;
  wire       next_aen  = wr_ctrl ? hwdata[`SPS_AEN_BIT] : auto_page_enable;

  // Read data is taken from the next values so that a read right after
  // a write sees the written byte with no wait state.
  wire [7:0] rd_byte = (ap_idx == `SPS_IDX_CTRL)   ? {7'h00, next_aen} :
                       (ap_idx == `SPS_IDX_PAGE)   ? next_page :
                       (ap_idx == `SPS_IDX_MIDDLE) ? next_mid  :
                       (ap_idx == `SPS_IDX_BOTTOM) ? next_bot  :
                       8'h00;
  wire        rd_take = ap_take & ~hwrite;
  wire [31:0] next_rd = ap_mapped ? {24'h000000, rd_byte} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Core access decode
  // ----------------------------------------------------------------
  wire acc_sfr = core_acc.valid & core_acc.direct & core_acc.addr[7];
  wire acc_all = acc_sfr & is_all_pages(core_acc.addr);

  sps_decode_t next_decode;
  assign next_decode.sfr_sel    = acc_sfr;
  assign next_decode.ram_sel    = core_acc.valid & ~acc_sfr;
  assign next_decode.all_pages  = acc_all;
  assign next_decode.page_valid = acc_all |
                                  (acc_sfr & is_known_page(current_page_select));
  assign next_decode.bit_err    = acc_sfr & core_acc.bit_op &
                                  ~is_bit_addr(core_acc.addr);
  assign next_decode.page       = current_page_select;
  assign next_decode.addr       = core_acc.addr;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      current_page_select <= `SPS_RST_PAGE;
      page_stack_middle   <= `SPS_RST_PAGE;
      page_stack_bottom   <= `SPS_RST_PAGE;
      auto_page_enable    <= `SPS_RST_AEN;
    end
    else
    begin
      current_page_select <= next_page;
      page_stack_middle   <= next_mid;
      page_stack_bottom   <= next_bot;
      auto_page_enable    <= next_aen;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dp_valid  <= 1'b0;
      dp_write  <= 1'b0;
      dp_idx    <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      decode    <= '0;
    end
    else
    begin
      dp_valid  <= ap_take & ap_mapped;
      dp_write  <= hwrite;
      dp_idx    <= ap_idx;
      hrdata    <= rd_take ? next_rd : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      decode    <= next_decode;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  push_page_a: assert property (
    push |=> current_page_select == ($past(irq_evt.is_can) ? 8'h0C : 8'h00))
    else $error("Page not loaded on interrupt entry.");

  push_shift_a: assert property (
    push |=> page_stack_middle == $past(current_page_select) &&
             page_stack_bottom == $past(page_stack_middle))
    else $error("Stack did not shift on interrupt entry.");

  pop_restore_a: assert property (
    pop |=> current_page_select == $past(page_stack_middle))
    else $error("Page not restored on return.");

  pop_bottom_a: assert property (
    pop |=> page_stack_middle == $past(page_stack_bottom) &&
            page_stack_bottom == 8'h00)
    else $error("Bottom entry not popped.");

  auto_off_a: assert property (
    (irq_evt.enter || irq_evt.ret) && !auto_page_enable && !dp_wr
      |=> $stable(current_page_select) && $stable(page_stack_middle) &&
          $stable(page_stack_bottom))
    else $error("Stack moved with paging disabled.");

  sw_write_a: assert property (
    wr_mid && !push && !pop |=> page_stack_middle == $past(wbyte) &&
      $stable(current_page_select) && $stable(page_stack_bottom))
    else $error("Stack write disturbed other entries.");

  enable_hold_a: assert property (
    auto_page_enable && !(wr_ctrl && !hwdata[0]) |=> auto_page_enable)
    else $error("Paging enable dropped without a write.");

  ctrl_read_a: assert property (
    rd_take && ap_mapped && ap_idx == 8'h84
      |=> hrdata == {31'h0, auto_page_enable})
    else $error("Control register read wrong.");

  sfr_route_a: assert property (
    core_acc.valid && core_acc.direct && core_acc.addr[7]
      |=> decode.sfr_sel && !decode.ram_sel)
    else $error("Direct upper access not routed to registers.");

  bit_check_a: assert property (
    acc_sfr && core_acc.bit_op |=> decode.bit_err == ($past(core_acc.addr[2:0]) != 3'h0))
    else $error("Bit access check wrong.");

  port_all_a: assert property (
    acc_sfr && core_acc.addr == 8'h90 |=> decode.all_pages && decode.page_valid)
    else $error("Port register not visible on every page.");

  reset_values_a: assert property (
    $past(sys_rst) |-> current_page_select == 8'h00 && page_stack_middle == 8'h00 &&
      page_stack_bottom == 8'h00)
    else $error("Stack not cleared by reset.");

  reset_enable_a: assert property (
    $past(sys_rst) |-> auto_page_enable)
    else $error("Paging enable not set by reset.");

  page_read_a: assert property (
    rd_take && ap_mapped && ap_idx == 8'hA7
      |=> hrdata == {24'h000000, current_page_select})
    else $error("Page selector read wrong.");

  middle_read_a: assert property (
    rd_take && ap_mapped && ap_idx == 8'h85
      |=> hrdata == {24'h000000, page_stack_middle})
    else $error("Middle entry read wrong.");

  bottom_read_a: assert property (
    rd_take && ap_mapped && ap_idx == 8'h86
      |=> hrdata == {24'h000000, page_stack_bottom})
    else $error("Bottom entry read wrong.");

  page_write_a: assert property (
    wr_page && !push && !pop |=> current_page_select == $past(wbyte) &&
      $stable(page_stack_middle) && $stable(page_stack_bottom))
    else $error("Page write disturbed the stack.");

  bottom_write_a: assert property (
    wr_bot && !push && !pop |=> page_stack_bottom == $past(wbyte) &&
      $stable(current_page_select) && $stable(page_stack_middle))
    else $error("Bottom write disturbed other entries.");

  ctrl_write_a: assert property (
    wr_ctrl |=> auto_page_enable == $past(hwdata[0]))
    else $error("Paging enable write lost.");

  idle_hold_a: assert property (
    !irq_evt.enter && !irq_evt.ret && !dp_wr
      |=> $stable(current_page_select) && $stable(page_stack_middle) &&
          $stable(page_stack_bottom))
    else $error("Stack moved without an event or write.");

  ram_route_a: assert property (
    core_acc.valid && !(core_acc.direct && core_acc.addr[7])
      |=> decode.ram_sel && !decode.sfr_sel)
    else $error("Indirect or lower access not routed to memory.");

  page_follow_a: assert property (
    core_acc.valid |=> decode.page == $past(current_page_select) &&
      decode.addr == $past(core_acc.addr))
    else $error("Decoded page or address wrong.");

  page_known_a: assert property (
    acc_sfr && !acc_all |=> decode.page_valid ==
      ($past(current_page_select) inside {8'h00, 8'h0C, 8'h0F}))
    else $error("Page validity decoded wrong.");

endmodule : sps_page_stack

/* File: rtl/sps_pkg.sv */
// Types shared by the page stack and its users.
package sps_pkg;
  typedef struct packed {
    logic       valid;
    logic       direct;
    logic       bit_op;
    logic [7:0] addr;
  } sps_access_t;

  typedef struct packed {
    logic enter;
    logic is_can;
    logic ret;
  } sps_irq_t;

  typedef struct packed {
    logic       sfr_sel;
    logic       ram_sel;
    logic       all_pages;
    logic       page_valid;
    logic       bit_err;
    logic [7:0] page;
    logic [7:0] addr;
  } sps_decode_t;
endpackage : sps_pkg

/* File: testbench/sps_core_model.sv */
// Behavioural processor core and interrupt controller facing the page stack.
`timescale 1ns/1ps
module sps_core_model
  import sps_pkg::*;
(
  input  wire logic   clk,
  output sps_access_t core_acc,
  output sps_irq_t    irq_evt
);
  initial
  begin
    core_acc = '0;
    irq_evt  = '0;
  end
  // Entry pulses with the vector fetch, return with the return instruction.
  task automatic irq(input logic ent, input logic can);
    @(posedge clk);
    irq_evt <= '{enter: ent, is_can: can, ret: !ent};
    @(posedge clk);
    irq_evt <= '0;
  endtask : irq
  // Drives one access for one cycle, assigned or not, on the page already selected.
  task automatic acc(input logic dir, input logic bop, input logic [7:0] a);
    @(posedge clk);
    core_acc <= '{valid: 1'b1, direct: dir, bit_op: bop, addr: a};
    @(posedge clk);
    core_acc <= '0;
  endtask : acc
endmodule : sps_core_model

/* File: testbench/sps_page_stack_tb.sv */
// Self-checking testbench of the paged register decoder and page stack.
`timescale 1ns/1ps
module sps_page_stack_tb;
  import sps_pkg::*;
  logic        clk, sys_rst, hsel, hwrite, hreadyout, hresp, auto_page_enable;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  current_page_select;
  sps_access_t core_acc;
  sps_irq_t    irq_evt;
  sps_decode_t decode, d;
  int          err_total, cmp_count, cyc;
  sps_core_model sps_core_model_inst (.clk(clk), .core_acc(core_acc), .irq_evt(irq_evt));
  sps_page_stack sps_page_stack_inst (.clk(clk), .sys_rst(sys_rst), .core_acc(core_acc),
    .irq_evt(irq_evt), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .decode(decode),
    .current_page_select(current_page_select), .auto_page_enable(auto_page_enable));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  // The run is short, so a hang shows long before this ceiling.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      err_total++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("Error at %0t: read %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic chk_out(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("Error at %0t: output %h expected %h", $time, g, e);
    end
  endtask : chk_out
  // Flags are sfr_sel, ram_sel, all_pages, page_valid, bit_err from the top.
  task automatic chk_dec(input sps_decode_t g, input logic [4:0] f, input logic [7:0] p,
                         input logic [7:0] a);
    cmp_count++;
    if (g !== {f, p, a})
    begin
      err_total++;
      $display("Error at %0t: decode %h expected %h", $time, g, {f, p, a});
    end
  endtask : chk_dec
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] dat);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= dat;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk_out({7'h00, hresp}, 8'h00);
  endtask : ahb
  task automatic chkst(input logic [7:0] p, input logic [7:0] m, input logic [7:0] b);
    ahb(1'b0, 32'h29C, 32'h0);
    chk(rd, {24'h0, p});
    ahb(1'b0, 32'h214, 32'h0);
    chk(rd, {24'h0, m});
    ahb(1'b0, 32'h218, 32'h0);
    chk(rd, {24'h0, b});
    chk_out(current_page_select, p);
  endtask : chkst
  task automatic dec(input logic dir, input logic bop, input logic [7:0] a);
    sps_core_model_inst.acc(dir, bop, a);
    @(posedge clk);
    d = decode;
  endtask : dec
  task automatic t_reset;
    ahb(1'b0, 32'h210, 32'h0);
    chk(rd, 32'h1);
    chkst(8'h00, 8'h00, 8'h00);
    ahb(1'b1, 32'h210, 32'hFFFF_FFFF);
    ahb(1'b0, 32'h210, 32'h0);
    chk(rd, 32'h1);
    ahb(1'b1, 32'h210, 32'hFFFF_FFFE);
    ahb(1'b0, 32'h210, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, 32'h210, 32'h1);
    ahb(1'b1, 32'h400, 32'h0000_0055);
    chkst(8'h00, 8'h00, 8'h00);
    ahb(1'b0, 32'h400, 32'h0);
    chk(rd, 32'h0);
  endtask : t_reset
  task automatic t_stack;
    ahb(1'b1, 32'h29C, 32'hFFFF_FF0F);
    chkst(8'h0F, 8'h00, 8'h00);
    sps_core_model_inst.irq(1'b1, 1'b1);
    chkst(8'h0C, 8'h0F, 8'h00);
    sps_core_model_inst.irq(1'b1, 1'b0);
    chkst(8'h00, 8'h0C, 8'h0F);
    sps_core_model_inst.irq(1'b0, 1'b0);
    chkst(8'h0C, 8'h0F, 8'h00);
    ahb(1'b1, 32'h214, 32'h05);
    chkst(8'h0C, 8'h05, 8'h00);
    sps_core_model_inst.irq(1'b0, 1'b0);
    chkst(8'h05, 8'h00, 8'h00);
  endtask : t_stack
  task automatic t_disable;
    ahb(1'b1, 32'h210, 32'h0);
    // The write lands at the edge the task returns on, so look one edge later.
    @(posedge clk);
    chk_out({7'h00, auto_page_enable}, 8'h00);
    sps_core_model_inst.irq(1'b1, 1'b1);
    chkst(8'h05, 8'h00, 8'h00);
    sps_core_model_inst.irq(1'b0, 1'b0);
    chkst(8'h05, 8'h00, 8'h00);
    ahb(1'b1, 32'h210, 32'h1);
  endtask : t_disable
  task automatic t_decode;
    dec(1'b1, 1'b0, 8'h90);
    chk_dec(d, 5'h16, 8'h05, 8'h90);
    dec(1'b0, 1'b0, 8'h90);
    chk_dec(d, 5'h08, 8'h05, 8'h90);
    dec(1'b1, 1'b0, 8'hC1);
    chk_dec(d, 5'h10, 8'h05, 8'hC1);
    ahb(1'b1, 32'h29C, 32'h0F);
    dec(1'b1, 1'b0, 8'hC1);
    chk_dec(d, 5'h12, 8'h0F, 8'hC1);
    dec(1'b1, 1'b1, 8'h81);
    chk_dec(d, 5'h13, 8'h0F, 8'h81);
    dec(1'b1, 1'b1, 8'h88);
    chk_dec(d, 5'h12, 8'h0F, 8'h88);
  endtask : t_decode
  task automatic t_rerun;
    ahb(1'b1, 32'h210, 32'h0);
    ahb(1'b1, 32'h218, 32'h33);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    ahb(1'b0, 32'h210, 32'h0);
    chk(rd, 32'h1);
    chkst(8'h00, 8'h00, 8'h00);
  endtask : t_rerun
  initial
  begin
    sys_rst   = 1'b1;
    hsel      = 1'b0;
    haddr     = '0;
    htrans    = '0;
    hwrite    = 1'b0;
    hsize     = 3'h2;
    hwdata    = '0;
    err_total = 0;
    cmp_count = 0;
    cyc       = 0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_stack();
    t_disable();
    t_decode();
    t_rerun();
    wrap_up();
  end
endmodule : sps_page_stack_tb
